// ===== xps_params.svh
// Constants for the crosspoint parallel programming block.
`ifndef XPS_PARAMS_SVH
`define XPS_PARAMS_SVH

// ----------------------------------------------------------------------
// Matrix geometry
// ----------------------------------------------------------------------
`define XPS_NUM_OUT 8
`define XPS_NUM_IN 16
`define XPS_IDX_W 3
`define XPS_SRC_W 4
`define XPS_ENTRY_W 5

// ----------------------------------------------------------------------
// Entry field positions
// ----------------------------------------------------------------------
`define XPS_ON_BIT 4
`define XPS_SRC_MSB 3
`define XPS_SRC_LSB 0

// ----------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------
`define XPS_ADDR_W 8
`define XPS_OFS_CTRL 8'h00
`define XPS_OFS_STATUS 8'h04
`define XPS_OFS_LATCH 8'h20
`define XPS_OFS_SHIFT 8'h40
`define XPS_BANK_SEL_LATCH 3'h1
`define XPS_BANK_SEL_SHIFT 3'h2
`define XPS_CTRL_MUTE_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define XPS_RST_MUTE 1'h0
`define XPS_RST_ON 8'h00
`define XPS_RST_OE_N 8'hff
`define XPS_RST_SRC 32'h0000_0000
`define XPS_RST_MASK 8'h00
`define XPS_RST_IDX 3'h0
`define XPS_RST_RDATA 32'h0000_0000

`endif

// ===== xps_pkg.sv
// Types shared by the crosspoint programming modules.
`include "xps_params.svh"

package xps_pkg;

  // ----------------------------------------------------------------------
  // Entry and bank types
  // ----------------------------------------------------------------------
  typedef logic [`XPS_ENTRY_W-1:0] xps_entry_t;
  typedef xps_entry_t [`XPS_NUM_OUT-1:0] xps_bank_t;

  // ----------------------------------------------------------------------
  // Top-level control state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic clk_prev;
    logic mute;
    logic [`XPS_NUM_OUT-1:0] on;
    logic [`XPS_NUM_OUT*`XPS_SRC_W-1:0] src;
    logic [`XPS_NUM_OUT-1:0] sig;
    logic [`XPS_NUM_OUT-1:0] oe_n;
    logic [`XPS_NUM_OUT-1:0] pending;
    logic [`XPS_NUM_OUT-1:0] loaded;
    logic [`XPS_IDX_W-1:0] last_idx;
    logic [31:0] rdata;
  } xps_top_state_t;

  // ----------------------------------------------------------------------
  // Entry store state
  // ----------------------------------------------------------------------
  typedef struct packed {
    xps_bank_t shift;
    xps_bank_t latch;
  } xps_store_state_t;

endpackage : xps_pkg

// ===== xps_store_if.sv
// Interface between the control logic and the entry store.
`timescale 1ns/1ps
`include "xps_params.svh"

interface xps_store_if;
  logic wr_en;
  logic [`XPS_IDX_W-1:0] wr_idx;
  xps_pkg::xps_entry_t wr_entry;
  logic apply;
  xps_pkg::xps_bank_t shift_q;
  xps_pkg::xps_bank_t latch_q;

  modport ctrl (
    output wr_en,
    output wr_idx,
    output wr_entry,
    output apply,
    input shift_q,
    input latch_q
  );

  modport store (
    input wr_en,
    input wr_idx,
    input wr_entry,
    input apply,
    output shift_q,
    output latch_q
  );
endinterface : xps_store_if

// ===== xps_entry_store.sv
// Shift register entries and apply latches of the crosspoint.
`timescale 1ns/1ps
`include "xps_params.svh"

module xps_entry_store (
  // Clock
  input wire logic clk_in,
  // Control side
  xps_store_if.store st
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // The entries carry no reset: a reset must leave them as they are, and
  // after power-up they hold whatever the flip-flops come up with.
  xps_pkg::xps_store_state_t state;
  xps_pkg::xps_store_state_t next_state;

  always_comb begin
    next_state = state;
    if (st.wr_en) begin
      next_state.shift[st.wr_idx] = st.wr_entry;
    end
    if (st.apply) begin
      next_state.latch = state.shift;
    end
  end

  always_ff @(posedge clk_in) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // While applying, the latches are transparent to the shift entries.
  assign st.shift_q = state.shift;
  assign st.latch_q = st.apply ? state.shift : state.latch;

endmodule : xps_entry_store

// ===== xps_top.sv
// Parallel programming control of a 16 by 8 crosspoint switch.
//
// Function
// - One clock and apply changes one output.
// - Reset only disables every output; here reset also clears mute, pending, loaded, last_idx and rdata.
// - Reset keeps shift entries and latches intact.
// - Entries are undefined until first loaded.
// - Select and apply low copy entries to matrix.
// - Output index picks the entry written.
// - Source bits route input; on bit enables.
// - Disabled entry ignores its source bits.
// - Falling clock edge captures index and data.
// - Matrix keeps old programming while apply high.
// - Several captures take effect together on apply.
// - Latches pass entries while select and apply low.
// - Mode low is serial, high is parallel.
// - Captures happen only while select is low.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "xps_params.svh"

module xps_top #(
  parameter int ADDR_W = `XPS_ADDR_W
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Programming pins
  input wire logic DEV_SEL_N_IN,
  input wire logic PORT_MODE_SELECT_IN,
  input wire logic APPLY_N_IN,
  input wire logic PROG_CLK_IN,
  input wire logic [`XPS_IDX_W-1:0] OUTPUT_INDEX_IN,
  input wire logic [`XPS_SRC_W-1:0] SOURCE_SELECT_IN,
  input wire logic OUTPUT_ON_IN,
  // Switched signals
  input wire logic [`XPS_NUM_IN-1:0] SIGNAL_IN,
  output logic [`XPS_NUM_OUT-1:0] SIGNAL_OUT,
  output logic [`XPS_NUM_OUT-1:0] SIGNAL_OE_N_OUT,
  // Matrix programming view
  output logic [`XPS_NUM_OUT-1:0] ROUTE_ENABLE_OUT,
  output logic [`XPS_NUM_OUT*`XPS_SRC_W-1:0] ROUTE_SOURCE_OUT,
  // Register port
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Returns the enable bit of an entry.
  function automatic logic entry_on(input xps_pkg::xps_entry_t e);
    entry_on = e[`XPS_ON_BIT];
  endfunction : entry_on

  // Returns the source field of an entry.
  function automatic logic [`XPS_SRC_W-1:0] entry_src(
    input xps_pkg::xps_entry_t e
  );
    entry_src = e[`XPS_SRC_MSB:`XPS_SRC_LSB];
  endfunction : entry_src

  // Turns an output index into a one-hot mask.
  function automatic logic [`XPS_NUM_OUT-1:0] idx_mask(
    input logic [`XPS_IDX_W-1:0] idx,
    input logic en
  );
    idx_mask = '0;
    idx_mask[idx] = en;
  endfunction : idx_mask

  // Picks one of the sixteen inputs.
  function automatic logic pick_input(
    input logic [`XPS_NUM_IN-1:0] inputs,
    input logic [`XPS_SRC_W-1:0] sel
  );
    pick_input = inputs[sel];
  endfunction : pick_input

  // Widens an entry to a read word.
  function automatic logic [31:0] entry_word(input xps_pkg::xps_entry_t e);
    entry_word = {{(32-`XPS_ENTRY_W){1'b0}}, e};
  endfunction : entry_word

  // ----------------------------------------------------------------------
  // State and entry store
  // ----------------------------------------------------------------------
  xps_pkg::xps_top_state_t state;
  xps_pkg::xps_top_state_t next_state;

  xps_store_if store_bus();

  xps_entry_store u_store (
    .clk_in(CLK_IN),
    .st(store_bus.store)
  );

  // ----------------------------------------------------------------------
  // Programming pin decode
  // ----------------------------------------------------------------------
  logic prog_fall;
  logic capture;
  logic apply;
  logic [`XPS_NUM_OUT-1:0] cap_mask;
  xps_pkg::xps_entry_t cap_entry;

  // The clock pin is sampled; a high sample followed by a low one is the
  // capturing edge.
  assign prog_fall = state.clk_prev & ~PROG_CLK_IN;
  // Serial mode shares the shift entries but is not handled here, so a
  // clock edge in serial mode leaves the entries alone.
  assign capture = prog_fall & ~DEV_SEL_N_IN &
    PORT_MODE_SELECT_IN;
  assign apply = ~DEV_SEL_N_IN & ~APPLY_N_IN;
  assign cap_mask = idx_mask(OUTPUT_INDEX_IN, capture);
  assign cap_entry = {OUTPUT_ON_IN, SOURCE_SELECT_IN};

  assign store_bus.wr_en = capture;
  assign store_bus.wr_idx = OUTPUT_INDEX_IN;
  assign store_bus.wr_entry = cap_entry;
  assign store_bus.apply = apply;

  // ----------------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------------
  logic [2:0] bank_sel;
  logic [`XPS_IDX_W-1:0] bank_idx;
  logic word_aligned;
  logic [31:0] read_word;

  assign bank_sel = REG_ADDR_IN[7:5];
  assign bank_idx = REG_ADDR_IN[4:2];
  assign word_aligned = (REG_ADDR_IN[1:0] == 2'h0) &&
    ((REG_ADDR_IN >> 8) == '0);

  always_comb begin
    read_word = 32'h0000_0000;
    if (!word_aligned) begin
      read_word = 32'h0000_0000;
    end else if (REG_ADDR_IN[7:0] == `XPS_OFS_CTRL) begin
      read_word[`XPS_CTRL_MUTE_BIT] = state.mute;
    end else if (REG_ADDR_IN[7:0] == `XPS_OFS_STATUS) begin
      read_word[7:0] = state.pending;
      read_word[15:8] = state.loaded;
      read_word[18:16] = state.last_idx;
      read_word[31:24] = state.on;
    end else if (bank_sel == `XPS_BANK_SEL_LATCH) begin
      read_word = entry_word(store_bus.latch_q[bank_idx]);
    end else if (bank_sel == `XPS_BANK_SEL_SHIFT) begin
      read_word = entry_word(store_bus.shift_q[bank_idx]);
    end else begin
      read_word = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.clk_prev = PROG_CLK_IN;

    // Control register.
    if (REG_WR_IN && word_aligned &&
        REG_ADDR_IN[7:0] == `XPS_OFS_CTRL) begin
      next_state.mute = REG_WDATA_IN[`XPS_CTRL_MUTE_BIT];
    end

    // Read data stands for the one cycle after the strobe.
    next_state.rdata = REG_RD_IN ? read_word : 32'h0000_0000;

    // Captured entries wait for the apply; a capture in the applying
    // cycle stays pending so it is not reported as applied early.
    next_state.pending = (apply ? `XPS_RST_MASK : state.pending) |
      cap_mask;
    next_state.loaded = state.loaded | cap_mask;
    if (capture) begin
      next_state.last_idx = OUTPUT_INDEX_IN;
    end

    // Matrix drive follows the latched entries.
    for (int i = 0; i < `XPS_NUM_OUT; i++) begin
      if (entry_on(store_bus.latch_q[i]) && !state.mute) begin
        next_state.on[i] = 1'b1;
        next_state.src[i*`XPS_SRC_W +: `XPS_SRC_W] =
          entry_src(store_bus.latch_q[i]);
        next_state.sig[i] = pick_input(SIGNAL_IN,
          entry_src(store_bus.latch_q[i]));
        next_state.oe_n[i] = 1'b0;
      end else begin
        next_state.on[i] = 1'b0;
        next_state.src[i*`XPS_SRC_W +: `XPS_SRC_W] = '0;
        next_state.sig[i] = 1'b0;
        next_state.oe_n[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset sets the whole top-level state, not just the drive side; the entries live in the store,
  // which has no reset at all.
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state.clk_prev <= 1'b1;
      state.mute <= `XPS_RST_MUTE;
      state.on <= `XPS_RST_ON;
      state.src <= `XPS_RST_SRC;
      state.sig <= `XPS_RST_ON;
      state.oe_n <= `XPS_RST_OE_N;
      state.pending <= `XPS_RST_MASK;
      state.loaded <= `XPS_RST_MASK;
      state.last_idx <= `XPS_RST_IDX;
      state.rdata <= `XPS_RST_RDATA;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign SIGNAL_OUT = state.sig;
  assign SIGNAL_OE_N_OUT = state.oe_n;
  assign ROUTE_ENABLE_OUT = state.on;
  assign ROUTE_SOURCE_OUT = state.src;
  assign REG_RDATA_OUT = state.rdata;

endmodule : xps_top

// ===== xps_checker.sv
// Assertion checker for the crosspoint programming pins and matrix outputs.
`timescale 1ns/1ps
module xps_checker (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Programming pins
  input wire logic DEV_SEL_N_IN,
  input wire logic PORT_MODE_SELECT_IN,
  input wire logic APPLY_N_IN,
  input wire logic PROG_CLK_IN,
  input wire logic [2:0] OUTPUT_INDEX_IN,
  input wire logic [3:0] SOURCE_SELECT_IN,
  input wire logic OUTPUT_ON_IN,
  // Switched signals and matrix view
  input wire logic [15:0] SIGNAL_IN,
  input wire logic [7:0] SIGNAL_OUT,
  input wire logic [7:0] SIGNAL_OE_N_OUT,
  input wire logic [7:0] ROUTE_ENABLE_OUT,
  input wire logic [31:0] ROUTE_SOURCE_OUT,
  // Register port
  input wire logic REG_WR_IN
);
  // ----------------------------------------------------------------------
  // Helper logic and properties
  // ----------------------------------------------------------------------
  logic prog_q;
  logic [15:0] sig_in_q;
  logic cap;
  logic [7:0] sig_exp;
  logic [7:0] src_any;
  function automatic logic [3:0] fld(input logic [31:0] v,
    input logic [2:0] i);
    return v[i*4 +: 4];
  endfunction : fld
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      prog_q <= 1'b1;
      sig_in_q <= 16'h0000;
    end else begin
      prog_q <= PROG_CLK_IN;
      sig_in_q <= SIGNAL_IN;
    end
  end
  always_comb begin
    cap = prog_q & ~PROG_CLK_IN & ~DEV_SEL_N_IN & PORT_MODE_SELECT_IN;
    for (int i = 0; i < 8; i++) begin
      sig_exp[i] = ROUTE_ENABLE_OUT[i] & sig_in_q[fld(ROUTE_SOURCE_OUT, 3'(i))];
      src_any[i] = |fld(ROUTE_SOURCE_OUT, 3'(i));
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence s_quiet;
    (APPLY_N_IN && RESETN_IN && !REG_WR_IN) [*3];
  endsequence
  sequence s_cap_applied;
    cap && !APPLY_N_IN && !REG_WR_IN ##1 !APPLY_N_IN && !DEV_SEL_N_IN;
  endsequence
  property p_reset_off;
    $rose(RESETN_IN) |-> ROUTE_ENABLE_OUT == 8'h00 && SIGNAL_OE_N_OUT == 8'hff;
  endproperty
  property p_oe;
    SIGNAL_OE_N_OUT == ~ROUTE_ENABLE_OUT;
  endproperty
  property p_off_quiet;
    ((SIGNAL_OUT | src_any) & ~ROUTE_ENABLE_OUT) == 8'h00;
  endproperty
  property p_hold;
    s_quiet |=> $stable(ROUTE_ENABLE_OUT) && $stable(ROUTE_SOURCE_OUT);
  endproperty
  property p_desel;
    (DEV_SEL_N_IN && RESETN_IN && !REG_WR_IN) [*3] |=>
      $stable(ROUTE_ENABLE_OUT) && $stable(ROUTE_SOURCE_OUT);
  endproperty
  property p_apply_on;
    s_cap_applied |=>
      ROUTE_ENABLE_OUT[$past(OUTPUT_INDEX_IN, 2)] == $past(OUTPUT_ON_IN, 2);
  endproperty
  property p_apply_src;
    s_cap_applied ##0 $past(OUTPUT_ON_IN) |=>
      fld(ROUTE_SOURCE_OUT, $past(OUTPUT_INDEX_IN, 2)) ==
      $past(SOURCE_SELECT_IN, 2);
  endproperty
  property p_route_sig;
    SIGNAL_OUT == sig_exp;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("outputs on at reset release");
  a_oe: assert property (p_oe)
    else $error("drive enable disagrees with route");
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled output active");
  a_hold: assert property (p_hold)
    else $error("matrix changed with apply high");
  a_desel: assert property (p_desel)
    else $error("matrix changed while deselected");
  a_apply_on: assert property (p_apply_on)
    else $error("applied enable wrong");
  a_apply_src: assert property (p_apply_src)
    else $error("applied source wrong");
  a_route_sig: assert property (p_route_sig)
    else $error("output not routed");
endmodule : xps_checker

bind xps_top xps_checker i_chk (.CLK_IN, .RESETN_IN, .DEV_SEL_N_IN,
  .PORT_MODE_SELECT_IN, .APPLY_N_IN, .PROG_CLK_IN, .OUTPUT_INDEX_IN,
  .SOURCE_SELECT_IN, .OUTPUT_ON_IN, .SIGNAL_IN, .SIGNAL_OUT,
  .SIGNAL_OE_N_OUT, .ROUTE_ENABLE_OUT, .ROUTE_SOURCE_OUT, .REG_WR_IN);

// ===== xps_host_model.sv
// Host controller model that drives the programming pins.
`timescale 1ns/1ps
module xps_host_model (
  // Clock
  input wire logic clk_in,
  // Programming pins
  output logic sel_n_out,
  output logic mode_out,
  output logic apply_n_out,
  output logic pclk_out,
  output logic [2:0] idx_out,
  output logic [4:0] entry_out
);
  initial begin
    sel_n_out = 1'b1;
    mode_out = 1'b1;
    apply_n_out = 1'b1;
    pclk_out = 1'b1;
    idx_out = 3'h0;
    entry_out = 5'h00;
  end
  // Index and data are inverted once taken so stale values are never used.
  task automatic put(input logic sel_n, input logic mode,
    input logic [2:0] idx, input logic [4:0] e);
    @(posedge clk_in);
    sel_n_out <= sel_n;
    mode_out <= mode;
    idx_out <= idx;
    entry_out <= e;
    @(posedge clk_in);
    pclk_out <= 1'b0;
    @(posedge clk_in);
    pclk_out <= 1'b1;
    idx_out <= ~idx;
    entry_out <= ~e;
  endtask : put
  task automatic apply(input logic lo);
    @(posedge clk_in);
    sel_n_out <= 1'b0;
    apply_n_out <= ~lo;
  endtask : apply
endmodule : xps_host_model

// ===== xps_top_tb.sv
// Self-checking testbench of the crosspoint parallel programming block.
`timescale 1ns/1ps
module xps_top_tb;
  // ----------------------------------------------------------------------
  // Signals, models and tasks
  // ----------------------------------------------------------------------
  logic clk_in = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] sig_in = 16'ha5c3;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sel_n, mode, apply_n, pclk;
  logic [2:0] idx;
  logic [4:0] entry;
  logic [7:0] sig_out, oe_n, route_en;
  logic [31:0] route_src, rdata;
  logic [4:0] exp_e [8];
  int failures = 0;
  int checked = 0;
  initial forever #10 clk_in = ~clk_in;
  xps_host_model i_host (.clk_in(clk_in), .sel_n_out(sel_n), .mode_out(mode),
    .apply_n_out(apply_n), .pclk_out(pclk), .idx_out(idx), .entry_out(entry));
  xps_top i_dut (.CLK_IN(clk_in), .RESETN_IN(resetn), .DEV_SEL_N_IN(sel_n),
    .PORT_MODE_SELECT_IN(mode), .APPLY_N_IN(apply_n), .PROG_CLK_IN(pclk),
    .OUTPUT_INDEX_IN(idx), .SOURCE_SELECT_IN(entry[3:0]),
    .OUTPUT_ON_IN(entry[4]), .SIGNAL_IN(sig_in), .SIGNAL_OUT(sig_out),
    .SIGNAL_OE_N_OUT(oe_n), .ROUTE_ENABLE_OUT(route_en),
    .ROUTE_SOURCE_OUT(route_src), .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
    .REG_RDATA_OUT(rdata));
  task automatic end_of_test;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask : reg_wr_t
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : chk_reg
  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic chk_matrix(input logic m);
    logic [7:0] en;
    logic [31:0] s;
    logic [7:0] so;
    for (int i = 0; i < 8; i++) begin
      en[i] = exp_e[i][4] & ~m;
      s[i*4 +: 4] = en[i] ? exp_e[i][3:0] : 4'h0;
      so[i] = en[i] & sig_in[exp_e[i][3:0]];
    end
    check(route_en, en);
    check(oe_n, 8'(~en));
    check(route_src, s);
    check(sig_out, so);
  endtask : chk_matrix
  task automatic load(input logic [2:0] i, input logic [4:0] e);
    i_host.put(1'b0, 1'b1, i, e);
    exp_e[i] = e;
  endtask : load
  task automatic chk_shift;
    for (int i = 0; i < 8; i++) chk_reg(8'h40 + 8'(4 * i), exp_e[i]);
  endtask : chk_shift
  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    #100us;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk_in);
    #1 check(route_en, 8'h00);
    check(oe_n, 8'hff);
    repeat (2) @(posedge clk_in);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) load(3'(i), {i != 3, 4'hf - 4'(i)});
    chk_shift();
    i_host.apply(1'b1);
    settle();
    chk_matrix(1'b0);
    i_host.apply(1'b0);
    i_host.put(1'b0, 1'b1, 3'h5, 5'h12);
    settle();
    chk_matrix(1'b0);
    exp_e[5] = 5'h12;
    chk_shift();
    chk_reg(8'h04, 32'hf705_ff20);
    i_host.apply(1'b1);
    settle();
    chk_matrix(1'b0);
    load(3'h3, 5'h17);
    settle();
    chk_matrix(1'b0);
    i_host.apply(1'b0);
    i_host.put(1'b1, 1'b1, 3'h6, 5'h00);
    chk_reg(8'h58, exp_e[6]);
    i_host.put(1'b0, 1'b0, 3'h6, 5'h00);
    chk_reg(8'h58, exp_e[6]);
    reg_wr_t(8'h00, 32'h0000_0001);
    settle();
    chk_matrix(1'b1);
    chk_reg(8'h00, 32'h0000_0001);
    reg_wr_t(8'h00, 32'h0000_0000);
    chk_reg(8'h10, 32'h0000_0000);
    @(posedge clk_in);
    sig_in <= ~sig_in;
    settle();
    chk_matrix(1'b0);
    resetn <= 1'b0;
    @(posedge clk_in);
    #1 check(route_en, 8'h00);
    resetn <= 1'b1;
    chk_shift();
    for (int i = 0; i < 8; i++) chk_reg(8'h20 + 8'(4 * i), exp_e[i]);
    settle();
    chk_matrix(1'b0);
    end_of_test();
  end
endmodule : xps_top_tb
